// ==== design/cpm_pin_mux.v ====
// Comparator pin and analog switch selection with its register port
//
// What this block does
// - Comparator B off leaves its pins general I/O
// - Positive select only: positive pin is analog input
// - Shared select only: low reference plus common pin
// - Both selects: common and positive pins analog
// - Output enabled, no selects: drive output pin
// - Op amp negative, positive pin, output driven
// - Low reference, common pin, output pin driven
// - Common and positive pins inputs, output driven
// - Comparator A drives pin five when both enabled
// - Otherwise pin five follows its direction bit
// - Analog selects, comparator A off: plain I/O
// - Analog selects, A on: buffer, pull-high off
// - Calibration ref one: common pin common mode
// - Calibration ref zero: negative pin common mode
// - Normal mode switch settings follow selects
// - Shared select picks op amp or pin, resets one
// - B positive select: low reference or pin
// - Forced selects read one, restore afterwards
// - Route controls forced low by priority
`timescale 1ns/1ps
`include "cpm_defines.vh"

module cpm_pin_mux #(
  parameter DATA_W = 8,
  parameter ADDR_W = 4
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Register port
  input wire [ADDR_W-1:0] reg_addr,
  input wire [DATA_W-1:0] reg_wdata,
  input wire reg_we,
  input wire reg_re,
  output reg [DATA_W-1:0] reg_rdata,
  // Comparator results
  input wire comp_a_result,
  input wire comp_b_result,
  // Shared pins
  output reg shared_pin_two_analog,
  output reg shared_pin_three_analog,
  output reg shared_pin_four_out,
  output reg shared_pin_four_oe,
  input wire shared_pin_five_in,
  output reg shared_pin_five_out,
  output reg shared_pin_five_oe,
  output reg shared_pin_five_input_enable,
  output reg shared_pin_five_pullup_enable,
  // Comparator enables and comparator B sources
  output reg comparator_a_enable_out,
  output reg comparator_b_enable_out,
  output reg comp_b_neg_from_pin,
  output reg comp_b_pos_from_pin,
  // Analog switches
  output reg noninv_pin_switch,
  output reg neg_source_switch,
  output reg neg_source_to_pin,
  output reg cal_switch_a,
  output reg cal_switch_b,
  output reg cal_short_switch,
  output reg opamp_first_route_switch,
  output reg opamp_second_route_switch
);

  // --------------------------------------------------------------------
  // Software registers
  // --------------------------------------------------------------------
  reg [DATA_W-1:0] ctrl_a_reg;
  reg [DATA_W-1:0] ctrl_b_reg;
  reg [DATA_W-1:0] cal_a_reg;
  reg [DATA_W-1:0] port_reg;

  // Write strobes, one per register; unmapped addresses write nothing
  wire we_ctrl_a = reg_we & (reg_addr == `CPM_ADDR_CTRL_A);
  wire we_ctrl_b = reg_we & (reg_addr == `CPM_ADDR_CTRL_B);
  wire we_cal_a = reg_we & (reg_addr == `CPM_ADDR_CAL_A);
  wire we_port = reg_we & (reg_addr == `CPM_ADDR_PORT);

  // Forced bits keep the written value underneath, so it returns later
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_a_reg <= `CPM_RST_CTRL_A;
    end else if (we_ctrl_a) begin
      ctrl_a_reg <= reg_wdata;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_b_reg <= `CPM_RST_CTRL_B;
    end else if (we_ctrl_b) begin
      ctrl_b_reg <= reg_wdata;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_a_reg <= `CPM_RST_CAL_A;
    end else if (we_cal_a) begin
      cal_a_reg <= reg_wdata;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_reg <= `CPM_RST_PORT;
    end else if (we_port) begin
      port_reg <= reg_wdata;
    end
  end

  // --------------------------------------------------------------------
  // Effective selection
  // --------------------------------------------------------------------
  wire a_en = ctrl_a_reg[`CPM_A_EN];
  wire a_outen = ctrl_a_reg[`CPM_A_OUTEN];
  wire b_en = ctrl_b_reg[`CPM_B_EN];
  wire b_outen = ctrl_b_reg[`CPM_B_OUTEN];
  wire b_possel = ctrl_b_reg[`CPM_B_POSSEL];
  wire cal_mode = cal_a_reg[`CPM_CAL_MODE];
  wire ref_sel = cal_a_reg[`CPM_CAL_REFSEL];
  wire dir_in = port_reg[`CPM_P_DIR];

  // Calibration forces both input selects high
  wire noninv_eff = ctrl_a_reg[`CPM_A_NONINV] | cal_mode;
  wire a_neg_eff = ctrl_a_reg[`CPM_A_NEGSEL] | cal_mode;

  // Pin input has priority over both op amp routes; first beats second
  wire route1_eff = ~noninv_eff & port_reg[`CPM_P_ROUTE1];
  wire route2_eff = ~noninv_eff & ~port_reg[`CPM_P_ROUTE1]
    & port_reg[`CPM_P_ROUTE2];

  // Comparator B pin usage
  wire p2_an = b_en & noninv_eff;
  wire p3_an = b_en & b_possel;
  wire p4_drv = b_en & b_outen;

  // Pin five
  wire p5_drv = a_en & a_outen;
  wire p5_an = a_en & noninv_eff & a_neg_eff;
  wire p5_oe = p5_drv | ~dir_in;
  wire p5_out = p5_drv ? comp_a_result : port_reg[`CPM_P_DATA];
  // An input buffer that is switched off reads as a constant one
  wire p5_pin_rd = p5_an ? 1'b1 : shared_pin_five_in;
  wire p5_rd = dir_in ? p5_pin_rd : port_reg[`CPM_P_DATA];

  // --------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------
  reg [DATA_W-1:0] rdata_next;
  always @* begin
    rdata_next = {DATA_W{1'b0}};
    if (reg_re) begin
      case (reg_addr)
        `CPM_ADDR_CTRL_A: begin
          rdata_next = ctrl_a_reg;
          rdata_next[`CPM_A_NONINV] = noninv_eff;
          rdata_next[`CPM_A_NEGSEL] = a_neg_eff;
        end
        `CPM_ADDR_CTRL_B: rdata_next = ctrl_b_reg;
        `CPM_ADDR_CAL_A: rdata_next = cal_a_reg;
        `CPM_ADDR_PORT: rdata_next = port_reg;
        `CPM_ADDR_STATUS: rdata_next = status_word;
        default: rdata_next = {DATA_W{1'b0}};
      endcase
    end
  end

  // Status word, built bit by bit so free bits read as zero
  reg [DATA_W-1:0] status_word;
  always @* begin
    status_word = {DATA_W{1'b0}};
    status_word[`CPM_S_PIN5] = p5_rd;
    status_word[`CPM_S_ROUTE1] = route1_eff;
    status_word[`CPM_S_ROUTE2] = route2_eff;
    status_word[`CPM_S_P2AN] = p2_an;
    status_word[`CPM_S_P3AN] = p3_an;
    status_word[`CPM_S_P4DRV] = p4_drv;
    status_word[`CPM_S_P5DRV] = p5_drv;
    status_word[`CPM_S_P5AN] = p5_an;
  end

  // Next values of the pin and switch flops
  wire p5_ie_next = ~p5_an;
  wire p5_pu_next = port_reg[`CPM_P_PULLUP] & ~p5_an;
  wire cal_a_next = ~cal_mode | ref_sel;
  wire cal_b_next = ~cal_mode | ~ref_sel;

  // --------------------------------------------------------------------
  // Read data register
  // --------------------------------------------------------------------
  // Every output is a flip-flop, so pins and switches lag settings by one
  // cycle; the analog side settles far slower than that anyway.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= {DATA_W{1'b0}};
    end else begin
      reg_rdata <= rdata_next;
    end
  end

  // --------------------------------------------------------------------
  // Comparator B pins
  // --------------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shared_pin_two_analog <= 1'b0;
      shared_pin_three_analog <= 1'b0;
      shared_pin_four_out <= 1'b0;
      shared_pin_four_oe <= 1'b0;
    end else begin
      shared_pin_two_analog <= p2_an;
      shared_pin_three_analog <= p3_an;
      shared_pin_four_out <= comp_b_result;
      shared_pin_four_oe <= p4_drv;
    end
  end

  // --------------------------------------------------------------------
  // Pin five
  // --------------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shared_pin_five_out <= 1'b0;
      shared_pin_five_oe <= 1'b0;
      shared_pin_five_input_enable <= 1'b1;
      shared_pin_five_pullup_enable <= 1'b0;
    end else begin
      shared_pin_five_out <= p5_out;
      shared_pin_five_oe <= p5_oe;
      shared_pin_five_input_enable <= p5_ie_next;
      shared_pin_five_pullup_enable <= p5_pu_next;
    end
  end

  // --------------------------------------------------------------------
  // Comparator enables and comparator B sources
  // --------------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      comparator_a_enable_out <= 1'b0;
      comparator_b_enable_out <= 1'b0;
      comp_b_neg_from_pin <= 1'b1;
      comp_b_pos_from_pin <= 1'b1;
    end else begin
      comparator_a_enable_out <= a_en;
      comparator_b_enable_out <= b_en;
      comp_b_neg_from_pin <= noninv_eff;
      comp_b_pos_from_pin <= b_possel;
    end
  end

  // --------------------------------------------------------------------
  // Input routing switches
  // --------------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      noninv_pin_switch <= 1'b1;
      neg_source_switch <= 1'b1;
      neg_source_to_pin <= 1'b1;
      opamp_first_route_switch <= 1'b0;
      opamp_second_route_switch <= 1'b0;
    end else begin
      noninv_pin_switch <= noninv_eff;
      neg_source_switch <= 1'b1;
      neg_source_to_pin <= a_neg_eff;
      opamp_first_route_switch <= route1_eff;
      opamp_second_route_switch <= route2_eff;
    end
  end

  // --------------------------------------------------------------------
  // Calibration switches
  // --------------------------------------------------------------------
  // Only comparator A calibration is modelled; B has no cal switches here
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_switch_a <= 1'b1;
      cal_switch_b <= 1'b1;
      cal_short_switch <= 1'b0;
    end else begin
      cal_switch_a <= cal_a_next;
      cal_switch_b <= cal_b_next;
      cal_short_switch <= cal_mode;
    end
  end

endmodule // cpm_pin_mux

// ==== design/cpm_defines.vh ====
// Register map, field positions and reset values of the comparator pin mux
`ifndef CPM_DEFINES_VH
`define CPM_DEFINES_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define CPM_ADDR_CTRL_A 4'h0
`define CPM_ADDR_CTRL_B 4'h1
`define CPM_ADDR_CAL_A 4'h2
`define CPM_ADDR_PORT 4'h3
`define CPM_ADDR_STATUS 4'h4

// ----------------------------------------------------------------------
// Comparator A control fields
// ----------------------------------------------------------------------
`define CPM_A_EN 0
`define CPM_A_NEGSEL 1
`define CPM_A_OUTEN 2
`define CPM_A_NONINV 7

// ----------------------------------------------------------------------
// Comparator B control fields
// ----------------------------------------------------------------------
`define CPM_B_EN 0
`define CPM_B_POSSEL 1
`define CPM_B_OUTEN 2

// ----------------------------------------------------------------------
// Calibration fields
// ----------------------------------------------------------------------
`define CPM_CAL_REFSEL 5
`define CPM_CAL_MODE 6

// ----------------------------------------------------------------------
// Pin five and op amp routing fields
// ----------------------------------------------------------------------
`define CPM_P_DATA 0
`define CPM_P_DIR 1
`define CPM_P_ROUTE1 2
`define CPM_P_ROUTE2 3
`define CPM_P_PULLUP 4

// ----------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------
`define CPM_S_PIN5 0
`define CPM_S_ROUTE1 1
`define CPM_S_ROUTE2 2
`define CPM_S_P2AN 3
`define CPM_S_P3AN 4
`define CPM_S_P4DRV 5
`define CPM_S_P5DRV 6
`define CPM_S_P5AN 7

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CPM_RST_CTRL_A 8'h82
`define CPM_RST_CTRL_B 8'h02
`define CPM_RST_CAL_A 8'h00
`define CPM_RST_PORT 8'h02

`endif

// ==== verif/cpm_pin_mux_properties.sv ====
// Port checker for the comparator pin mux
`timescale 1ns/1ps
`include "cpm_defines.vh"
module cpm_pin_mux_props (
  // Clock, reset and register port
  input logic clk, rst_n, reg_we, comp_b_result,
  input logic [3:0] reg_addr,
  input logic [7:0] reg_wdata,
  // Pins and switches
  input logic shared_pin_three_analog, shared_pin_four_out,
  input logic shared_pin_four_oe, shared_pin_five_oe,
  input logic shared_pin_five_input_enable, shared_pin_five_pullup_enable,
  input logic comparator_a_enable_out, comparator_b_enable_out,
  input logic noninv_pin_switch, neg_source_switch, neg_source_to_pin,
  input logic cal_switch_a, cal_switch_b, cal_short_switch,
  input logic opamp_first_route_switch, opamp_second_route_switch
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // A write followed by a quiet cycle, so no later write masks it
  sequence s_b_on;
    reg_we && reg_addr == `CPM_ADDR_CTRL_B && reg_wdata[2] && reg_wdata[0]
      ##1 !reg_we;
  endsequence
  sequence s_b_off;
    reg_we && reg_addr == `CPM_ADDR_CTRL_B && !reg_wdata[0] ##1 !reg_we;
  endsequence
  sequence s_dir_out;
    reg_we && reg_addr == `CPM_ADDR_PORT && !reg_wdata[1] ##1 !reg_we;
  endsequence
  a_b_out_drive: assert property (s_b_on |=> shared_pin_four_oe)
    else $error("pin four not driven");
  a_b_off_release: assert property (s_b_off |=> !shared_pin_three_analog
    && !shared_pin_four_oe) else $error("pins not released");
  a_b_off_quiet: assert property (!comparator_b_enable_out |->
    !shared_pin_three_analog) else $error("pin three analog while off");
  a_pin4_follow: assert property (shared_pin_four_oe |->
    shared_pin_four_out == $past(comp_b_result)) else $error("pin four stale");
  a_pin5_dir_out: assert property (s_dir_out |=> shared_pin_five_oe)
    else $error("pin five not output");
  a_route_excl: assert property (!(opamp_first_route_switch
    && opamp_second_route_switch)) else $error("both routes closed");
  a_route_forced: assert property (noninv_pin_switch |->
    !opamp_first_route_switch && !opamp_second_route_switch)
    else $error("route closed with pin switch");
  a_cal_switches: assert property (cal_short_switch |-> noninv_pin_switch
    && neg_source_switch && neg_source_to_pin
    && (cal_switch_a ^ cal_switch_b)) else $error("calibration switches");
  a_norm_switches: assert property (!cal_short_switch |->
    cal_switch_a && cal_switch_b) else $error("normal switches");
  a_p5_analog: assert property (!shared_pin_five_input_enable |->
    comparator_a_enable_out && !shared_pin_five_pullup_enable)
    else $error("pin five analog state");
endmodule // cpm_pin_mux_props
bind cpm_pin_mux cpm_pin_mux_props props_u (.*);

// ==== verif/cpm_far_side.sv ====
// Far side model: comparator outputs and the pin five wire
`timescale 1ns/1ps
module cpm_far_side (
  input logic clk, shared_pin_five_out, shared_pin_five_oe,
  input logic shared_pin_five_pullup_enable, ext_level,
  output logic comp_a_result = 1'b0, comp_b_result = 1'b0,
  output logic shared_pin_five_in
);
  // Results move every cycle so a stale sample is caught
  always @(posedge clk) comp_a_result <= ~comp_a_result;
  always @(posedge clk) comp_b_result <= comp_a_result;
  assign shared_pin_five_in = shared_pin_five_oe ? shared_pin_five_out :
    (shared_pin_five_pullup_enable | ext_level);
endmodule // cpm_far_side

// ==== verif/testbench.sv ====
// Self-checking bench for the comparator pin mux
`timescale 1ns/1ps
`include "cpm_defines.vh"
module testbench;
  logic clk = 0, rst_n = 0, reg_we = 0, reg_re = 0, ext_level = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, rd_val;
  logic comp_a_result, comp_b_result, shared_pin_five_in;
  logic shared_pin_two_analog, shared_pin_three_analog, shared_pin_five_oe;
  logic shared_pin_four_out, shared_pin_four_oe, shared_pin_five_out;
  logic shared_pin_five_input_enable, shared_pin_five_pullup_enable;
  logic comparator_a_enable_out, comparator_b_enable_out;
  logic comp_b_neg_from_pin, comp_b_pos_from_pin, neg_source_switch;
  logic noninv_pin_switch, neg_source_to_pin, cal_switch_a, cal_switch_b;
  logic cal_short_switch, opamp_first_route_switch, opamp_second_route_switch;
  int n_errors = 0, n_tests = 0, cyc = 0;
  cpm_pin_mux dut_u (.*);
  cpm_far_side far_u (.*);
  always #4 clk = ~clk;
  // ----
  // Bus and compare tasks
  // ----
  task automatic summarize;
    if (n_errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk1(string nm, logic e, logic g);
    chk(nm, {7'h00, e}, {7'h00, g});
  endtask
  task automatic rd(logic [3:0] a);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  task automatic rdchk(logic [3:0] a, logic [7:0] e);
    rd(a);
    chk($sformatf("reg %h", a), e, rd_val);
  endtask
  // Outputs land one edge after the register; one spare edge kept
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic wsw(logic [3:0] a, logic [7:0] d, logic [7:0] e);
    wr(a, d);
    chk("switches", e, {noninv_pin_switch, neg_source_switch,
      neg_source_to_pin, cal_switch_a, cal_switch_b, cal_short_switch,
      opamp_first_route_switch, opamp_second_route_switch});
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_reset;
    rdchk(`CPM_ADDR_CTRL_A, `CPM_RST_CTRL_A);
    rdchk(`CPM_ADDR_CTRL_B, `CPM_RST_CTRL_B);
    rdchk(`CPM_ADDR_PORT, `CPM_RST_PORT);
    rdchk(4'hf, 8'h00);
  endtask
  task automatic t_comp_b;
    logic [3:0] s;
    for (int i = 0; i < 16; i++) begin
      s = i[3:0];
      wr(`CPM_ADDR_CTRL_A, {s[2], 7'h00});
      wr(`CPM_ADDR_CTRL_B, {5'h00, s[3], s[1], s[0]});
      chk1("pin2", s[0] & s[2], shared_pin_two_analog);
      chk1("pin3", s[0] & s[1], shared_pin_three_analog);
      chk1("pin4", s[0] & s[3], shared_pin_four_oe);
      chk1("b_en", s[0], comparator_b_enable_out);
      if (s[0]) chk1("b_neg", s[2], comp_b_neg_from_pin);
      if (s[0]) chk1("b_pos", s[1], comp_b_pos_from_pin);
    end
  endtask
  task automatic t_pin5;
    logic [2:0] s;
    logic drv;
    for (int i = 0; i < 8; i++) begin
      s = i[2:0];
      drv = s[0] & s[1];
      wr(`CPM_ADDR_CTRL_A, {5'h00, s[1], 1'b0, s[0]});
      wr(`CPM_ADDR_PORT, {6'h00, s[2], 1'b1});
      rd(`CPM_ADDR_STATUS);
      chk1("p5_oe", drv | ~s[2], shared_pin_five_oe);
      chk1("p5_drv", drv, rd_val[`CPM_S_P5DRV]);
      chk1("a_en", s[0], comparator_a_enable_out);
      if (!drv) chk1("p5_rd", ~s[2], rd_val[`CPM_S_PIN5]);
      if (!drv && !s[2]) chk1("p5_out", 1'b1, shared_pin_five_out);
    end
  endtask
  task automatic t_analog5;
    logic [1:0] s;
    for (int i = 0; i < 4; i++) begin
      s = i[1:0];
      wr(`CPM_ADDR_CTRL_A, {7'h41, s[0]});
      wr(`CPM_ADDR_PORT, {3'h0, 1'b1, 2'h0, s[1], 1'b0});
      rd(`CPM_ADDR_STATUS);
      chk1("p5_ie", ~s[0], shared_pin_five_input_enable);
      chk1("p5_pu", ~s[0], shared_pin_five_pullup_enable);
      chk1("p5_rd", s[1], rd_val[`CPM_S_PIN5]);
    end
  endtask
  task automatic t_cal;
    wsw(`CPM_ADDR_PORT, 8'h0e, 8'hf8);
    wsw(`CPM_ADDR_CTRL_A, 8'h80, 8'hd8);
    wsw(`CPM_ADDR_CTRL_A, 8'h01, 8'h5a);
    wsw(`CPM_ADDR_PORT, 8'h0a, 8'h59);
    wsw(`CPM_ADDR_CAL_A, 8'h60, 8'hf4);
    rdchk(`CPM_ADDR_CTRL_A, 8'h83);
    wsw(`CPM_ADDR_CAL_A, 8'h40, 8'hec);
    wsw(`CPM_ADDR_CAL_A, 8'h00, 8'h59);
    rdchk(`CPM_ADDR_CTRL_A, 8'h01);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_comp_b;
    t_pin5;
    t_analog5;
    t_cal;
    summarize;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      summarize;
    end
  end
endmodule // testbench
